/* File: lldram_pkg.sv */
// constants, types and decode helpers of the low-latency dram command/data port
// Behaviour
// - multiplexed mode sends address in two halves
// - refresh needs bank only, may repeat back-to-back
// - second half rebuilt through fixed ball permutation
// - second-half bits beyond configured width are ignored
// - decoded address width shrinks with burst length
// - read outputs unterminated while driving read data
// - write data and mask terminated whenever mode bit 9 is set
// - deselect starts nothing, cancels nothing
// - read: select low, write and refresh high
// - write: select and write low, refresh high
// - read data aligned to free-running read strobes
// - read valid rises with first beat
// - read valid drops at burst end, outputs released
// - back-to-back reads give gap-free data
// - write data taken one cycle after read latency
// - masked write beat is not stored
// - mode load takes opcode from address 0..17
// - commands and address sampled on rising clock
// - multiplexed mode adds one latency cycle
package lldram_pkg;

   localparam int ADDR_W        = 22;
   localparam int BANK_W        = 3;
   localparam int MUX_BALLS     = 11;
   localparam int MODE_W        = 18;
   localparam int MODE_CFG_LSB  = 0;
   localparam int MODE_CFG_W    = 3;
   localparam int MODE_BL_LSB   = 3;
   localparam int MODE_BL_W     = 2;
   localparam int MODE_MUX_BIT  = 5;
   localparam int MODE_TERM_BIT = 9;
   localparam int LAT_SLOTS     = 9;
   localparam int SYNC_STAGES   = 2;
   localparam logic [MODE_W-1:0] MODE_RESET = 18'h00000;

   localparam logic [1:0] BL_2 = 2'h0;
   localparam logic [1:0] BL_4 = 2'h1;
   localparam logic [1:0] BL_8 = 2'h2;

   // first-half ball numbers and the address bit each carries in the second half
   localparam logic [4:0] FIRST_BALL [MUX_BALLS] = '{5'h00, 5'h03, 5'h04, 5'h05, 5'h08, 5'h09,
                                                     5'h0A, 5'h0D, 5'h0E, 5'h11, 5'h12};
   localparam logic [4:0] SECOND_BIT [MUX_BALLS] = '{5'h14, 5'h01, 5'h02, 5'h15, 5'h06, 5'h07,
                                                     5'h13, 5'h0B, 5'h0C, 5'h10, 5'h0F};

   typedef enum logic [2:0] {
      CMD_DESELECT,
      CMD_MODE_LOAD,
      CMD_READ,
      CMD_WRITE,
      CMD_REFRESH
   } lldram_cmd_t;

   function automatic lldram_cmd_t lldram_decode(input logic cs_n, input logic we_n,
                                                 input logic ref_n);
      lldram_cmd_t c;
      c = CMD_DESELECT;
      if (!cs_n)
      begin
         case ({we_n, ref_n})
            2'b00:   c = CMD_MODE_LOAD;
            2'b11:   c = CMD_READ;
            2'b01:   c = CMD_WRITE;
            2'b10:   c = CMD_REFRESH;
            default: c = CMD_DESELECT;
         endcase
      end
      return c;
   endfunction

   // read latency in the non-multiplexed setting; row cycle time has the same figures
   function automatic logic [3:0] lldram_cycles(input logic [MODE_CFG_W-1:0] cfg);
      case (cfg)
         3'h2:    return 4'h6;
         3'h3:    return 4'h8;
         3'h4:    return 4'h3;
         3'h5:    return 4'h5;
         default: return 4'h4;
      endcase
   endfunction

   function automatic logic [3:0] lldram_beats(input logic [1:0] bl);
      case (bl)
         BL_4:    return 4'h4;
         BL_8:    return 4'h8;
         default: return 4'h2;
      endcase
   endfunction

endpackage

/* File: lldram_wr_if.sv */
// carrier for write beats crossing from the write data clock to the system clock
`timescale 1ns/100ps
`default_nettype none
interface lldram_wr_if #(parameter int DATA_W = 9);
   logic              req_tgl;
   logic              ack_tgl;
   logic [DATA_W-1:0] data;
   logic              mask;
   modport cap  (output req_tgl, output data, output mask, input ack_tgl);
   modport core (input req_tgl, input data, input mask, output ack_tgl);
endinterface
`default_nettype wire

/* File: lldram_wr_capture.sv */
// write data clock side: samples data and mask, hands them over by toggle handshake
`timescale 1ns/100ps
`default_nettype none
module lldram_wr_capture #(
   parameter int DATA_W = 9
) (
   input  wire logic              write_data_clk, // host write data clock
   input  wire logic              reset_n,        // system reset, resynchronised here
   input  wire logic [DATA_W-1:0] write_data,     // write data pins
   input  wire logic              write_mask,     // high: beat must not be stored
   lldram_wr_if.cap               wr              // handshake to the core
);
   import lldram_pkg::*;

   typedef struct packed {
      logic              rst_s1;
      logic              rst_s2;
      logic              ack_s1;
      logic              ack_s2;
      logic              req_tgl;
      logic [DATA_W-1:0] data;
      logic              mask;
   } lldram_cap_t;

   lldram_cap_t cap_reg;
   lldram_cap_t cap_next;

   always_comb
   begin
      cap_next        = cap_reg;
      cap_next.rst_s1 = reset_n;
      cap_next.rst_s2 = cap_reg.rst_s1;
      cap_next.ack_s1 = wr.ack_tgl;
      cap_next.ack_s2 = cap_reg.ack_s1;
      if (!cap_reg.rst_s2)
      begin
         cap_next.req_tgl = 1'b0;
         cap_next.data    = '0;
         cap_next.mask    = 1'b1;
      end
      // word stays still until the core has acknowledged it
      else if (cap_reg.ack_s2 == cap_reg.req_tgl)
      begin
         cap_next.data    = write_data;
         cap_next.mask    = write_mask;
         cap_next.req_tgl = ~cap_reg.req_tgl;
      end
   end

   always_ff @(posedge write_data_clk)
   begin
      cap_reg <= cap_next;
   end

   assign wr.req_tgl = cap_reg.req_tgl;
   assign wr.data    = cap_reg.data;
   assign wr.mask    = cap_reg.mask;

endmodule
`default_nettype wire

/* File: lldram_cmd_port.sv */
// device side command decode, latency pipes, burst engines and storage array
`timescale 1ns/100ps
`default_nettype none
module lldram_cmd_port #(
   parameter int DATA_W = 9,   // data bits per beat
   parameter int COL_W  = 3    // address bits kept for the storage index
) (
   input  wire logic                         clk,              // system clock
   input  wire logic                         reset_n,          // synchronous reset
   input  wire logic                         ce,               // low freezes all system-clock state
   input  wire logic                         write_data_clk,   // host write clock
   input  wire logic                         cs_n,             // chip select
   input  wire logic                         we_n,             // write enable
   input  wire logic                         ref_n,            // refresh strobe
   input  wire logic [lldram_pkg::ADDR_W-1:0] addr,            // address balls
   input  wire logic [lldram_pkg::BANK_W-1:0] bank,            // bank number
   input  wire logic                         cfg_x18,          // wide data config
   input  wire logic [DATA_W-1:0]            write_data,       // write data pins
   input  wire logic                         write_mask,       // write beat mask
   output logic      [DATA_W-1:0]            read_data,        // read data pins
   output logic                              read_data_oe_n,   // low while driving
   output logic                              read_valid,       // read data valid
   output logic                              read_strobe_clk,  // free-running strobe
   output logic                              read_strobe_clk_n,// its complement
   output logic                              read_term_on,     // read pin termination
   output logic                              write_term_on,    // write pin termination
   output logic                              row_busy,         // row cycle running
   output logic                              cmd_illegal       // command in second half
);
   import lldram_pkg::*;

   localparam int IDX_W = BANK_W + COL_W;
   localparam int DEPTH = 1 << IDX_W;
   localparam int PIN_W = 4 + BANK_W + ADDR_W;

   initial
   begin
      if (DATA_W < 1 || COL_W < 1 || COL_W > 6)
      begin
         $error("lldram_cmd_port: unsupported DATA_W or COL_W");
      end
   end

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      logic [PIN_W-1:0]                    p1;
      logic [PIN_W-1:0]                    p2;
      logic                                req_s1;
      logic                                req_s2;
      logic                                ack_tgl;
      logic [DATA_W-1:0]                   wb_data;
      logic                                wb_mask;
      logic [MODE_W-1:0]                   mode;
      logic                                half_pend;
      logic                                half_wr;
      logic [ADDR_W-1:0]                   half_ax;
      logic [BANK_W-1:0]                   half_bank;
      logic [3:0]                          rc_cnt;
      logic [LAT_SLOTS-1:0]                rq_v;
      logic [LAT_SLOTS-1:0]                wq_v;
      logic [LAT_SLOTS-1:0][IDX_W-1:0]     rq_i;
      logic [LAT_SLOTS-1:0][IDX_W-1:0]     wq_i;
      logic                                rd_on;
      logic                                wr_on;
      logic [IDX_W-1:0]                    rd_i;
      logic [IDX_W-1:0]                    wr_i;
      logic [3:0]                          rd_left;
      logic [3:0]                          wr_left;
      logic [DEPTH-1:0][DATA_W-1:0]        mem;
      logic [DATA_W-1:0]                   q;
      logic                                q_drive;
      logic                                q_valid;
      logic                                strobe;
      logic                                strobe_n;
      logic                                illegal;
   } lldram_core_t;

   lldram_core_t core_reg;
   lldram_core_t core_next;

   lldram_wr_if #(.DATA_W(DATA_W)) wr_link ();

   lldram_wr_capture #(.DATA_W(DATA_W)) u_capture (
      .write_data_clk (write_data_clk),
      .reset_n        (reset_n),
      .write_data     (write_data),
      .write_mask     (write_mask),
      .wr             (wr_link.cap)
   );

   // ****************************************************************
   // sampled pins and mode fields
   // ****************************************************************
   logic                  s_cs_n;
   logic                  s_we_n;
   logic                  s_ref_n;
   logic                  s_x18;
   logic [BANK_W-1:0]     s_bank;
   logic [ADDR_W-1:0]     s_addr;
   logic [MODE_CFG_W-1:0] m_cfg;
   logic [1:0]            m_bl;
   logic                  m_mux;
   logic                  m_term;
   logic [3:0]            m_lat;
   logic [3:0]            m_beats;

   assign {s_cs_n, s_we_n, s_ref_n, s_x18, s_bank, s_addr} = core_reg.p2;
   assign m_cfg   = core_reg.mode[MODE_CFG_LSB +: MODE_CFG_W];
   assign m_bl    = core_reg.mode[MODE_BL_LSB +: MODE_BL_W];
   assign m_mux   = core_reg.mode[MODE_MUX_BIT];
   assign m_term  = core_reg.mode[MODE_TERM_BIT];
   assign m_lat   = lldram_cycles(m_cfg);
   assign m_beats = lldram_beats(m_bl);

   // rebuilds the full address from the two halves
   function automatic logic [ADDR_W-1:0] join_halves(input logic [ADDR_W-1:0] ax,
                                                     input logic [ADDR_W-1:0] ay);
      logic [ADDR_W-1:0] full;
      full = '0;
      for (int i = 0; i < MUX_BALLS; i++)
      begin
         full[FIRST_BALL[i]] = ax[FIRST_BALL[i]];
         full[SECOND_BIT[i]] = ay[FIRST_BALL[i]];
      end
      return full;
   endfunction

   // bits above the configured address width read as zero
   function automatic logic [ADDR_W-1:0] width_mask(input logic [1:0] bl, input logic x18);
      logic [ADDR_W-1:0] m;
      int                w;
      m = '0;
      w = ADDR_W - int'(x18) - int'(bl);
      for (int i = 0; i < ADDR_W; i++)
      begin
         m[i] = (i < w);
      end
      return m;
   endfunction

   // ****************************************************************
   // command decode
   // ****************************************************************
   lldram_cmd_t       cmd;
   logic              iss_go;
   logic              iss_wr;
   logic [ADDR_W-1:0] iss_raw;
   logic [ADDR_W-1:0] iss_addr;
   logic [BANK_W-1:0] iss_bank;
   logic [IDX_W-1:0]  iss_idx;

   always_comb
   begin
      cmd      = lldram_decode(s_cs_n, s_we_n, s_ref_n);
      iss_go   = 1'b0;
      iss_wr   = 1'b0;
      iss_raw  = s_addr;
      iss_bank = s_bank;
      if (core_reg.half_pend)
      begin
         // second half: issue the held command; this cycle's command only sets the illegal flag
         iss_go   = 1'b1;
         iss_wr   = core_reg.half_wr;
         iss_raw  = join_halves(core_reg.half_ax, s_addr);
         iss_bank = core_reg.half_bank;
      end
      else if (!m_mux && (cmd == CMD_READ || cmd == CMD_WRITE))
      begin
         iss_go = 1'b1;
         iss_wr = (cmd == CMD_WRITE);
      end
      iss_addr = iss_raw & width_mask(m_bl, s_x18);
      iss_idx  = {iss_bank, iss_addr[COL_W-1:0]};
   end

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb
   begin
      core_next = core_reg;
      if (ce)
      begin
         core_next.p1      = {cs_n, we_n, ref_n, cfg_x18, bank, addr};
         core_next.p2      = core_reg.p1;
         core_next.req_s1  = wr_link.req_tgl;
         core_next.req_s2  = core_reg.req_s1;
         core_next.illegal = 1'b0;
         core_next.strobe   = ~core_reg.strobe;
         core_next.strobe_n = core_reg.strobe;
         if (core_reg.req_s2 != core_reg.ack_tgl)
         begin
            core_next.wb_data = wr_link.data;
            core_next.wb_mask = wr_link.mask;
            core_next.ack_tgl = core_reg.req_s2;
         end
         if (core_reg.rc_cnt != 4'h0)
         begin
            core_next.rc_cnt = core_reg.rc_cnt - 4'h1;
         end

         // latency pipes move one slot per cycle toward slot zero
         for (int i = 0; i < LAT_SLOTS - 1; i++)
         begin
            core_next.rq_v[i] = core_reg.rq_v[i+1];
            core_next.wq_v[i] = core_reg.wq_v[i+1];
            core_next.rq_i[i] = core_reg.rq_i[i+1];
            core_next.wq_i[i] = core_reg.wq_i[i+1];
         end
         core_next.rq_v[LAT_SLOTS-1] = 1'b0;
         core_next.wq_v[LAT_SLOTS-1] = 1'b0;

         // a deselect falls through here and leaves pipes running
         if (core_reg.half_pend)
         begin
            core_next.half_pend = 1'b0;
            core_next.illegal   = (cmd != CMD_DESELECT);
         end
         else
         begin
            case (cmd)
               CMD_MODE_LOAD:
               begin
                  core_next.mode = s_addr[MODE_W-1:0];
               end
               CMD_READ,
               CMD_WRITE:
               begin
                  if (m_mux)
                  begin
                     core_next.half_pend = 1'b1;
                     core_next.half_wr   = (cmd == CMD_WRITE);
                     core_next.half_ax   = s_addr;
                     core_next.half_bank = s_bank;
                  end
               end
               CMD_REFRESH:
               begin
                  core_next.rc_cnt = lldram_cycles(m_cfg) - 4'h1;
               end
               default:
               begin
                  core_next.half_pend = 1'b0;
               end
            endcase
         end

         if (iss_go && !iss_wr)
         begin
            core_next.rq_v[m_lat - 4'h1] = 1'b1;
            core_next.rq_i[m_lat - 4'h1] = iss_idx;
         end
         if (iss_go && iss_wr)
         begin
            core_next.wq_v[m_lat] = 1'b1;
            core_next.wq_i[m_lat] = iss_idx;
         end

         // read burst engine; a new burst takes over with no idle beat
         if (core_reg.rq_v[0])
         begin
            core_next.q       = core_reg.mem[core_reg.rq_i[0]];
            core_next.q_drive = 1'b1;
            core_next.q_valid = 1'b1;
            core_next.rd_on   = 1'b1;
            core_next.rd_i    = core_reg.rq_i[0] + IDX_W'(1);
            core_next.rd_left = m_beats - 4'h1;
         end
         else if (core_reg.rd_on)
         begin
            core_next.q       = core_reg.mem[core_reg.rd_i];
            core_next.rd_i    = core_reg.rd_i + IDX_W'(1);
            core_next.rd_left = core_reg.rd_left - 4'h1;
            core_next.rd_on   = (core_reg.rd_left != 4'h1);
         end
         else
         begin
            core_next.q_drive = 1'b0;
            core_next.q_valid = 1'b0;
         end

         // write burst engine; uses the latest beat from the write clock side
         if (core_reg.wq_v[0])
         begin
            if (!core_reg.wb_mask)
            begin
               core_next.mem[core_reg.wq_i[0]] = core_reg.wb_data;
            end
            core_next.wr_on   = 1'b1;
            core_next.wr_i    = core_reg.wq_i[0] + IDX_W'(1);
            core_next.wr_left = m_beats - 4'h1;
         end
         else if (core_reg.wr_on)
         begin
            if (!core_reg.wb_mask)
            begin
               core_next.mem[core_reg.wr_i] = core_reg.wb_data;
            end
            core_next.wr_i    = core_reg.wr_i + IDX_W'(1);
            core_next.wr_left = core_reg.wr_left - 4'h1;
            core_next.wr_on   = (core_reg.wr_left != 4'h1);
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         core_reg         <= '0;
         core_reg.mode    <= MODE_RESET;
         core_reg.wb_mask <= 1'b1;
         core_reg.strobe_n <= 1'b1;
         core_reg.p1      <= '1;
         core_reg.p2      <= '1;
      end
      else
      begin
         core_reg <= core_next;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign read_data         = core_reg.q;
   assign read_data_oe_n    = ~core_reg.q_drive;
   assign read_valid        = core_reg.q_valid;
   assign read_strobe_clk   = core_reg.strobe;
   assign read_strobe_clk_n = core_reg.strobe_n;
   assign read_term_on      = m_term & ~core_reg.q_drive;
   assign write_term_on     = m_term;
   assign row_busy          = (core_reg.rc_cnt != 4'h0);
   assign cmd_illegal       = core_reg.illegal;
   // acknowledge toggle back to the write clock side, lets it sample the next beat
   assign wr_link.ack_tgl   = core_reg.ack_tgl;

endmodule
`default_nettype wire

/* File: lldram_properties.sv */
// output checks of the dram command port
`timescale 1ns/100ps
`default_nettype none
// ****
// checker
// ****
module lldram_chk (
   input wire logic clk,            // system clock
   input wire logic reset_n,        // sync reset
   input wire logic ce,             // clock enable
   input wire logic read_data_oe_n, // low while driving
   input wire logic read_valid,     // beat valid
   input wire logic read_strobe_clk,// read strobe
   input wire logic read_strobe_clk_n, // its complement
   input wire logic read_term_on,   // read termination
   input wire logic write_term_on,  // write termination
   input wire logic cmd_illegal     // second-half command
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   valid_drive_a: assert property (read_valid == !read_data_oe_n)
      else $error("valid and drive differ");
   term_off_a: assert property (!read_data_oe_n |-> !read_term_on)
      else $error("termination on while driving");
   term_back_a: assert property (write_term_on && read_data_oe_n |-> read_term_on)
      else $error("termination not back after burst");
   write_term_a: assert property (read_term_on |-> write_term_on)
      else $error("write pins unterminated");
   strobe_run_a: assert property (ce |=> read_strobe_clk != $past(read_strobe_clk))
      else $error("read strobe stopped");
   strobe_pair_a: assert property (read_strobe_clk != read_strobe_clk_n)
      else $error("read strobes not complementary");
   burst_min_a: assert property ($rose(read_valid) |=> read_valid)
      else $error("burst shorter than two beats");
   illegal_pulse_a: assert property (cmd_illegal |=> !cmd_illegal)
      else $error("illegal flag longer than a cycle");
   pins_release_a: assert property ($fell(read_valid) |-> read_data_oe_n)
      else $error("outputs held after burst");
endmodule
bind lldram_cmd_port lldram_chk chk (.clk, .reset_n, .ce, .read_data_oe_n, .read_valid,
   .read_strobe_clk, .read_strobe_clk_n, .read_term_on, .write_term_on, .cmd_illegal);
`default_nettype wire

/* File: lldram_host.sv */
// host controller model: command strobes, address halves, write beats
`timescale 1ns/100ps
`default_nettype none
// ****
// host
// ****
module lldram_host (
   input  wire logic   clk,            // system clock
   output logic        write_data_clk, // write clock, free running
   output logic        cs_n,           // chip select
   output logic        we_n,           // write enable
   output logic        ref_n,          // refresh strobe
   output logic [21:0] addr,           // address balls
   output logic [2:0]  bank,           // bank number
   output logic [8:0]  write_data,     // write beat
   output logic        write_mask      // beat mask
);
   initial
   begin
      write_data_clk = 1'h0;
      {cs_n, we_n, ref_n} = 3'h7;
      addr = 22'h0;
      bank = 3'h0;
      write_data = 9'h0;
      write_mask = 1'h1;
   end
   always #7.5 write_data_clk = ~write_data_clk;
   // one cycle on the pins, changed just after the rising edge
   task drive(input logic [2:0] c, input logic [21:0] a, input logic [2:0] b);
      @(posedge clk);
      {cs_n, we_n, ref_n} <= c;
      addr <= a;
      bank <= b;
   endtask
   // beat is held until the next one, so the crossing sees a steady word
   task beat(input logic [8:0] d, input logic m);
      @(posedge clk);
      write_data <= d;
      write_mask <= m;
   endtask
endmodule
`default_nettype wire

/* File: tb.sv */
// self-checking bench of the dram command port
`timescale 1ns/100ps
`default_nettype none
// ****
// bench
// ****
module tb;
   import lldram_pkg::*;
   localparam logic [2:0] RD = 3'h3, WR = 3'h1, ML = 3'h0, RF = 3'h2, DS = 3'h7;
   logic clk = 1'h0;
   logic reset_n = 1'h0;
   logic ce = 1'h1;
   logic cfg_x18 = 1'h0;
   logic dclk, cs_n, we_n, ref_n, wm, valid, oe_n, rterm, wterm, busy, ill, qk, qk_n;
   logic [ADDR_W-1:0] addr;
   logic [2:0] bank;
   logic [8:0] wd, rd;
   int failures = 0;
   int compares = 0;
   int n;
   always #25 clk = ~clk;
   lldram_host host (.clk, .write_data_clk(dclk), .cs_n, .we_n, .ref_n, .addr, .bank,
      .write_data(wd), .write_mask(wm));
   lldram_cmd_port dut (.clk, .reset_n, .ce, .write_data_clk(dclk), .cs_n, .we_n, .ref_n,
      .addr, .bank, .cfg_x18, .write_data(wd), .write_mask(wm), .read_data(rd),
      .read_data_oe_n(oe_n), .read_valid(valid), .read_strobe_clk(qk),
      .read_strobe_clk_n(qk_n), .read_term_on(rterm), .write_term_on(wterm),
      .row_busy(busy), .cmd_illegal(ill));
   task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", s, exp, seen);
      end
   endtask
   task summarize;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task tick;
      @(posedge clk);
      #1;
   endtask
   // edges from command to first beat, bounded
   task await_valid(output int k);
      k = 0;
      do
      begin
         tick();
         k++;
      end
      while (valid !== 1'h1 && k < 20);
      if (valid !== 1'h1)
      begin
         failures++;
         summarize();
      end
   endtask
   task s_mode(input logic [21:0] op);
      host.drive(ML, op | 22'h3C0000, 3'h5);
      host.drive(DS, ~op, 3'h2);
      repeat (2) tick();
      chk("wterm", wterm, 1'h1);
      chk("rterm", rterm, 1'h1);
   endtask
   task s_write(input logic [21:0] a, a2, input logic [8:0] d, input logic m);
      host.beat(d, m);
      repeat (8) tick();
      host.drive(WR, a, 3'h1);
      host.drive(DS, a2, 3'h1);
      repeat (10) tick();
   endtask
   task s_read(input logic [21:0] a, a2, input logic [8:0] d, input int lat);
      logic s;
      host.drive(RD, a, 3'h1);
      host.drive(DS, a2, 3'h1);
      await_valid(n);
      chk("latency", n, lat);
      chk("rterm", rterm, 1'h0);
      chk("beat0", rd, d);
      s = qk;
      tick();
      chk("beat1", rd, d);
      chk("strobe", {qk, qk_n}, {~s, s});
      tick();
      chk("end", {valid, oe_n, rterm}, 3'h3);
      repeat (2) tick();
   endtask
   task s_stream;
      repeat (2)
      begin
         host.drive(RD, 22'h5, 3'h1);
         host.drive(DS, 22'h3FFFFA, 3'h6);
      end
      await_valid(n);
      repeat (3)
      begin
         tick();
         chk("stream", {valid, rd}, {1'h1, 9'h1A5});
      end
      repeat (4) tick();
   endtask
   // four-beat bursts at the shortest latency, wide data setting on for the run
   task s_burst4;
      s_mode(22'h00020C);
      @(posedge clk);
      cfg_x18 <= 1'h1;
      s_write(22'h200002, 22'h3FFFFF, 9'h13C, 1'h0);
      host.drive(RD, 22'h2, 3'h1);
      host.drive(DS, 22'h0, 3'h1);
      await_valid(n);
      chk("latency4", n, 5);
      repeat (4)
      begin
         chk("burst4", {valid, rd}, {1'h1, 9'h13C});
         tick();
      end
      chk("burst4 end", valid, 1'h0);
      @(posedge clk);
      cfg_x18 <= 1'h0;
   endtask
   task s_refresh;
      host.drive(RF, 22'h0, 3'h2);
      host.drive(DS, 22'h3FFFFF, 3'h5);
      n = 0;
      repeat (10)
      begin
         tick();
         n += (busy === 1'h1);
      end
      chk("row busy", n, 3);
   endtask
   // refreshes back to back, then a command in a second-half cycle
   task s_pair;
      host.drive(RF, 22'h0, 3'h2);
      host.drive(RF, 22'h0, 3'h3);
      host.drive(DS, 22'h3FFFFF, 3'h0);
      n = 0;
      repeat (6)
      begin
         tick();
         n += (busy === 1'h1);
      end
      chk("refresh pair", n, 4);
      host.drive(RD, 22'h1, 3'h1);
      host.drive(RF, 22'h18, 3'h1);
      host.drive(DS, 22'h0, 3'h0);
      n = 0;
      repeat (16)
      begin
         tick();
         n += (ill === 1'h1);
      end
      chk("illegal", n, 1);
   endtask
   initial
   begin
      repeat (4) @(posedge clk);
      reset_n <= 1'h1;
      #1;
      chk("reset", {valid, oe_n, busy, ill, wterm}, 5'h08);
      s_mode(22'h000200);
      s_write(22'h5, 22'h3FFFFA, 9'h1A5, 1'h0);
      s_read(22'h5, 22'h3FFFFA, 9'h1A5, 6);
      s_write(22'h5, 22'h3FFFFA, 9'h05A, 1'h1);
      s_read(22'h5, 22'h3FFFFA, 9'h1A5, 6);
      s_stream();
      s_refresh();
      s_mode(22'h000220);
      s_write(22'h1, 22'h18, 9'h0C3, 1'h0);
      s_read(22'h1, 22'h18, 9'h0C3, 7);
      s_pair();
      s_burst4();
      s_mode(22'h000200);
      s_read(22'h7, 22'h3FFFF8, 9'h0C3, 6);
      summarize();
   end
endmodule
`default_nettype wire
